// ---- dcch_pkg.sv ----
package dcch_pkg;
	// register byte offsets
	localparam logic [7:0] DCCH_CMD_OFS    = 8'h00;
	localparam logic [7:0] DCCH_STATUS_OFS = 8'h04;
	localparam logic [7:0] DCCH_REPLY_OFS  = 8'h08;
	localparam logic [7:0] DCCH_WAKE_OFS   = 8'h0c;
	localparam logic [7:0] DCCH_CTRL_OFS   = 8'h10;
	localparam logic [7:0] DCCH_PROBE_OFS  = 8'h14;

	// command word fields
	localparam int DCCH_OP_LSB    = 0;
	localparam int DCCH_HASP_BIT  = 4;
	localparam int DCCH_PARAM_LSB = 16;
	localparam int DCCH_OPT_W     = 9;

	// command codes
	typedef enum logic [3:0] {
		DCCH_OP_NOP    = 4'h0,
		DCCH_OP_MODE   = 4'h1,
		DCCH_OP_PROBE  = 4'h2,
		DCCH_OP_OPTS   = 4'h3,
		DCCH_OP_PAUSE  = 4'h4,
		DCCH_OP_RESUME = 4'h5,
		DCCH_OP_WBOOT  = 4'h6,
		DCCH_OP_ANTIR  = 4'h7,
		DCCH_OP_COMMIT = 4'h8,
		DCCH_OP_ENCF   = 4'h9
	} dcch_op_e;

	// power-up mode codes
	localparam logic [2:0] DCCH_MODE_SCL_EN  = 3'h2;
	localparam logic [2:0] DCCH_MODE_TOOL    = 3'h3;
	localparam logic [2:0] DCCH_MODE_SCL_DIS = 3'h5;

	// protocol option bit positions
	localparam int DCCH_OPT_STD    = 0;
	localparam int DCCH_OPT_ADDR   = 1;
	localparam int DCCH_OPT_ACK    = 2;
	localparam int DCCH_OPT_CSUM   = 3;
	localparam int DCCH_OPT_DUPLEX = 8;

	// non-volatile field select
	localparam int DCCH_NV_MODE = 0;
	localparam int DCCH_NV_OPTS = 1;
	localparam int DCCH_NV_RO   = 2;

	// wake-up override, probe length and queue depth
	localparam logic [7:0] DCCH_WAKE_CHAR = 8'h30;
	localparam longint     DCCH_CLK_HZ    = 100_000_000;
	localparam longint     DCCH_WAKE_MS   = 2000;
	localparam longint     DCCH_WAKE_CYC  = DCCH_WAKE_MS * DCCH_CLK_HZ / 1000;
	localparam int         DCCH_PROBE_CYC = 1000;
	localparam int         DCCH_Q_DEPTH   = 8;
endpackage

// ---- dcch_handler.sv ----
// How it works
// - mode codes 2, 5, 3 accepted; others ignored
// - mode 3 drops host commands silently
// - two consecutive '0' chars in window force command mode
// - mode write commits to non-volatile store
// - option query without parameter returns word
// - probe drives motor at maximum rated current
// - auto probe at power-up and encoder command
// - options held as nine-bit word
// - bits 1..3 address, ack, checksum
// - bit 0 standard only if others clear
// - bit 8 selects full duplex
// - pause stops execution, queue keeps filling
// - resume executes queued commands in order
// - restart clears faults, reloads, disables drive
// - restart reloads stored, not factory, values
// - anti-resonance 0 off, 1 on, queryable
// - commit copies volatile settings to store
//
// The plain strobed port and the address map were chosen for this implementation.
module dcch_handler
	import dcch_pkg::*;
#(
	parameter int     Q_DEPTH   = dcch_pkg::DCCH_Q_DEPTH,
	parameter longint WAKE_CYC  = dcch_pkg::DCCH_WAKE_CYC,
	parameter int     PROBE_CYC = dcch_pkg::DCCH_PROBE_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// non-volatile store
	input  wire logic [2:0]  nv_mode_i,
	input  wire logic [8:0]  nv_opts_i,
	input  wire logic        nv_ro_i,
	output logic             nv_wr_o,
	output logic      [2:0]  nv_sel_o,
	output logic      [2:0]  nv_mode_o,
	output logic      [8:0]  nv_opts_o,
	output logic             nv_ro_o,
	// power stage
	input  wire logic        fault_pin_i,
	input  wire logic [15:0] probe_meas_i,
	output logic             drive_en_o,
	output logic             probe_drive_o,
	output logic             anti_res_o,
	// link framing
	output logic             std_scl_o,
	output logic             addr_char_o,
	output logic             ack_en_o,
	output logic             csum_en_o,
	output logic             full_duplex_o,
	output logic             pwrup_pkt_o
);
	import dcch_pkg::*;

	localparam int QW = $clog2(Q_DEPTH);
	localparam int EW = 4 + 1 + DCCH_OPT_W;

	logic [2:0]           mode;
	logic [8:0]           opts;
	logic                 ro;
	logic                 init_done;
	logic                 scl_wake;
	logic                 wake_open;
	logic [31:0]          wake_cnt;
	logic [1:0]           zero_cnt;
	logic                 paused;
	logic                 fault;
	logic                 fault_s1;
	logic                 fault_s2;
	logic                 probe_busy;
	logic                 probe_req;
	logic [31:0]          probe_cnt;
	logic [15:0]          probe_res;
	logic [9:0]           reply;
	logic                 q_ovf;
	logic [EW-1:0]        q_mem [Q_DEPTH];
	logic [QW-1:0]        wr_ptr;
	logic [QW-1:0]        rd_ptr;
	logic [QW:0]          q_cnt;
	logic                 scl_active;
	logic                 cmd_wr;
	logic                 wboot;
	logic                 resume;
	logic                 push;
	logic                 pop;
	logic [EW-1:0]        head;
	dcch_op_e             op;
	logic                 hasp;
	logic [8:0]           prm;
	dcch_op_e             wr_op;

	function automatic logic valid_mode(input logic [8:0] v);
		return v == 9'(DCCH_MODE_SCL_EN) || v == 9'(DCCH_MODE_SCL_DIS)
			|| v == 9'(DCCH_MODE_TOOL);
	endfunction

	assign scl_active = init_done && (mode != DCCH_MODE_TOOL || scl_wake);
	assign cmd_wr     = ce_i && wr_i && addr_i == DCCH_CMD_OFS && scl_active;
	assign wr_op      = dcch_op_e'(wdata_i[DCCH_OP_LSB +: 4]);
	assign wboot      = cmd_wr && wr_op == DCCH_OP_WBOOT;
	assign resume     = cmd_wr && wr_op == DCCH_OP_RESUME;
	assign push       = cmd_wr && !wboot && !resume && q_cnt != (QW+1)'(Q_DEPTH);
	// probe blocks execution so queued commands never change settings mid-measurement; a restart still reloads them
	assign pop        = ce_i && init_done && !paused && !probe_busy && !probe_req
		&& q_cnt != '0 && !wboot;
	assign head       = q_mem[rd_ptr];
	assign op         = dcch_op_e'(head[3:0]);
	assign hasp       = head[4];
	assign prm        = head[EW-1:5];

	// pin synchroniser
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_s1 <= 1'b0;
			fault_s2 <= 1'b0;
		end else if (ce_i) begin
			fault_s1 <= fault_pin_i;
			fault_s2 <= fault_s1;
		end
	end

	// fault flag: a new fault beats the restart clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault <= 1'b0;
		end else if (ce_i) begin
			if (fault_s2) begin
				fault <= 1'b1;
			end else if (wboot) begin
				fault <= 1'b0;
			end
		end
	end

	// command queue, in-order
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			q_cnt  <= '0;
			q_ovf  <= 1'b0;
		end else if (wboot) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			q_cnt  <= '0;
			q_ovf  <= 1'b0;
		end else if (ce_i) begin
			if (push) begin
				q_mem[wr_ptr] <= {wdata_i[DCCH_PARAM_LSB +: DCCH_OPT_W],
					wdata_i[DCCH_HASP_BIT], wdata_i[3:0]};
				wr_ptr        <= (wr_ptr == QW'(Q_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == QW'(Q_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				q_cnt <= q_cnt + 1'b1;
			end else if (pop && !push) begin
				q_cnt <= q_cnt - 1'b1;
			end
			if (cmd_wr && !wboot && !resume && !push) begin
				q_ovf <= 1'b1;
			end
		end
	end

	// pause state: a resume in the same cycle as a pause wins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			paused <= 1'b0;
		end else if (ce_i) begin
			if (resume || wboot) begin
				paused <= 1'b0;
			end else if (pop && op == DCCH_OP_PAUSE) begin
				paused <= 1'b1;
			end
		end
	end

	// settings, startup load and non-volatile writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode      <= '0;
			opts      <= '0;
			ro        <= 1'b0;
			init_done <= 1'b0;
			reply     <= '0;
			nv_wr_o   <= 1'b0;
			nv_sel_o  <= '0;
			nv_mode_o <= '0;
			nv_opts_o <= '0;
			nv_ro_o   <= 1'b0;
		end else if (ce_i) begin
			nv_wr_o <= 1'b0;
			if (!init_done || wboot) begin
				mode      <= nv_mode_i;
				opts      <= nv_opts_i;
				ro        <= nv_ro_i;
				init_done <= 1'b1;
			end else if (pop) begin
				case (op)
					DCCH_OP_MODE: begin
						if (!hasp) begin
							reply <= {1'b1, 6'h0, mode};
						end else if (valid_mode(prm)) begin
							mode      <= prm[2:0];
							nv_mode_o <= prm[2:0];
							nv_sel_o  <= 3'h1 << DCCH_NV_MODE;
							nv_wr_o   <= 1'b1;
						end
					end
					DCCH_OP_OPTS: begin
						if (hasp) begin
							opts <= prm;
						end else begin
							reply <= {1'b1, opts};
						end
					end
					DCCH_OP_ANTIR: begin
						if (!hasp) begin
							reply <= {1'b1, 8'h0, ro};
						end else if (prm <= 9'h1) begin
							ro <= prm[0];
						end
					end
					DCCH_OP_COMMIT: begin
						nv_mode_o <= mode;
						nv_opts_o <= opts;
						nv_ro_o   <= ro;
						nv_sel_o  <= 3'h7;
						nv_wr_o   <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// motor probe: power-up, encoder command, or on demand
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			probe_req  <= 1'b1;
			probe_busy <= 1'b0;
			probe_cnt  <= '0;
			probe_res  <= '0;
		end else if (ce_i) begin
			if (probe_req && !probe_busy && init_done) begin
				probe_req  <= 1'b0;
				probe_busy <= 1'b1;
				probe_cnt  <= 32'(PROBE_CYC - 1);
			end else if (probe_busy) begin
				if (probe_cnt == '0) begin
					probe_busy <= 1'b0;
					probe_res  <= probe_meas_i;
				end else begin
					probe_cnt <= probe_cnt - 1'b1;
				end
			end else if (pop && (op == DCCH_OP_PROBE || op == DCCH_OP_ENCF)) begin
				probe_req <= 1'b1;
			end
		end
	end

	// wake-up window for configuration-tool mode
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_wake    <= 1'b0;
			wake_open   <= 1'b0;
			wake_cnt    <= '0;
			zero_cnt    <= '0;
			pwrup_pkt_o <= 1'b0;
		end else if (ce_i) begin
			pwrup_pkt_o <= 1'b0;
			if (!init_done) begin
				wake_open   <= nv_mode_i == DCCH_MODE_TOOL;
				pwrup_pkt_o <= nv_mode_i == DCCH_MODE_TOOL;
				wake_cnt    <= 32'(WAKE_CYC - 1);
			end else if (wake_open) begin
				wake_cnt <= wake_cnt - 1'b1;
				if (wake_cnt == '0) begin
					wake_open <= 1'b0;
				end
				if (wr_i && addr_i == DCCH_WAKE_OFS) begin
					if (wdata_i[7:0] != DCCH_WAKE_CHAR) begin
						zero_cnt <= '0;
					end else if (zero_cnt == 2'h1) begin
						scl_wake  <= 1'b1;
						wake_open <= 1'b0;
					end else begin
						zero_cnt <= zero_cnt + 1'b1;
					end
				end
			end
		end
	end

	// drive enable: restart always lands disabled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_en_o <= 1'b0;
		end else if (ce_i) begin
			if (wboot || fault) begin
				drive_en_o <= 1'b0;
			end else if (!init_done) begin
				drive_en_o <= nv_mode_i == DCCH_MODE_SCL_EN;
			end else if (wr_i && addr_i == DCCH_CTRL_OFS && scl_active) begin
				drive_en_o <= wdata_i[0];
			end
		end
	end

	// registered outputs toward power stage and link
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			probe_drive_o <= 1'b0;
			anti_res_o    <= 1'b0;
			std_scl_o     <= 1'b0;
			addr_char_o   <= 1'b0;
			ack_en_o      <= 1'b0;
			csum_en_o     <= 1'b0;
			full_duplex_o <= 1'b0;
		end else if (ce_i) begin
			probe_drive_o <= probe_busy;
			anti_res_o    <= ro;
			std_scl_o     <= opts[DCCH_OPT_STD] && opts[8:1] == '0;
			addr_char_o   <= opts[DCCH_OPT_ADDR];
			ack_en_o      <= opts[DCCH_OPT_ACK];
			csum_en_o     <= opts[DCCH_OPT_CSUM];
			full_duplex_o <= opts[DCCH_OPT_DUPLEX];
		end
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= '0;
			if (rd_i) begin
				if (addr_i == DCCH_STATUS_OFS) begin
					rdata_o <= {9'h0, 4'(q_cnt), q_ovf, fault, scl_active, paused,
						probe_busy, drive_en_o, ro, opts, mode};
				end else if (addr_i == DCCH_REPLY_OFS) begin
					rdata_o <= {reply[9], 22'h0, reply[8:0]};
				end else if (addr_i == DCCH_PROBE_OFS) begin
					rdata_o <= {16'h0, probe_res};
				end
			end
		end
	end
endmodule

// ---- dcch_handler_properties.sv ----
module dcch_props #(
	parameter int PROBE_CYC = 1000
) (
	// watched ports
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        nv_wr_o,
	input wire logic [2:0]  nv_sel_o,
	input wire logic [2:0]  nv_mode_o,
	input wire logic        fault_pin_i,
	input wire logic        drive_en_o,
	input wire logic        probe_drive_o,
	input wire logic        std_scl_o,
	input wire logic        addr_char_o,
	input wire logic        ack_en_o,
	input wire logic        csum_en_o,
	input wire logic        full_duplex_o,
	input wire logic        pwrup_pkt_o
);
	timeunit 1ns;
	timeprecision 1ps;

	int unsigned n_hi;

	// probe length too long for a repetition
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			n_hi <= 0;
		else
			n_hi <= probe_drive_o ? n_hi + 1 : 0;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside a read");
	property p_probe_len; $fell(probe_drive_o) |-> n_hi == PROBE_CYC; endproperty
	a_probe_len: assert property (p_probe_len)
		else $error("probe length wrong");
	property p_pwrup_probe; $rose(rst_n_i) |-> ##[1:4] probe_drive_o; endproperty
	a_pwrup_probe: assert property (p_pwrup_probe)
		else $error("no probe after power-up");
	// two sync stages, the flag and the enable register: off one edge after the fourth
	property p_fault_off; fault_pin_i [*4] |=> !drive_en_o; endproperty
	a_fault_off: assert property (p_fault_off)
		else $error("drive on during fault");
	property p_std_excl;
		std_scl_o |-> !(addr_char_o || ack_en_o || csum_en_o || full_duplex_o);
	endproperty
	a_std_excl: assert property (p_std_excl)
		else $error("standard framing with options");
	property p_nv_sel; nv_wr_o |-> nv_sel_o != 3'h0; endproperty
	a_nv_sel: assert property (p_nv_sel)
		else $error("store write without field");
	property p_nv_mode;
		nv_wr_o && nv_sel_o[0] |-> nv_mode_o inside {3'h2, 3'h3, 3'h5};
	endproperty
	a_nv_mode: assert property (p_nv_mode)
		else $error("unused mode stored");
	property p_pkt_pulse; pwrup_pkt_o |=> !pwrup_pkt_o; endproperty
	a_pkt_pulse: assert property (p_pkt_pulse)
		else $error("power-up packet too long");
endmodule

bind dcch_handler dcch_props #(.PROBE_CYC(PROBE_CYC)) i_props (.clk_i, .rst_n_i, .rd_i,
	.rdata_o, .nv_wr_o, .nv_sel_o, .nv_mode_o, .fault_pin_i, .drive_en_o, .probe_drive_o,
	.std_scl_o, .addr_char_o, .ack_en_o, .csum_en_o, .full_duplex_o, .pwrup_pkt_o);

// ---- dcch_nv_model.sv ----
module dcch_nv_model #(
	parameter logic [2:0] MODE0 = 3'h2,
	parameter logic [8:0] OPTS0 = 9'h001
) (
	// writes from the drive
	input  wire logic       clk_i,
	input  wire logic       wr_i,
	input  wire logic [2:0] sel_i,
	input  wire logic [2:0] mode_i,
	input  wire logic [8:0] opts_i,
	input  wire logic       ro_i,
	// stored startup values
	output logic      [2:0] mode_o,
	output logic      [8:0] opts_o,
	output logic            ro_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// no reset: contents outlive a power cycle
	initial begin
		mode_o = MODE0;
		opts_o = OPTS0;
		ro_o = 1'b0;
	end

	always @(posedge clk_i) begin
		if (wr_i) begin
			if (sel_i[0]) mode_o <= mode_i;
			if (sel_i[1]) opts_o <= opts_i;
			if (sel_i[2]) ro_o <= ro_i;
		end
	end
endmodule

// ---- test_drive_config_command_handler.sv ----
module test_drive_config_command_handler;
	timeunit 1ns;
	timeprecision 1ps;
	import dcch_pkg::*;

	logic clk_i, rst_n_i = 0, wr_i = 0, rd_i = 0, fault_pin_i = 0, seen_probe, seen_pkt;
	logic ce_i = 1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o, d;
	logic [15:0] meas = 16'hc35a;
	logic nv_wr_o, nv_ro_o, nv_ro_i, drive_en_o, probe_drive_o, anti_res_o, pwrup_pkt_o;
	logic std_scl_o, addr_char_o, ack_en_o, csum_en_o, full_duplex_o;
	logic [2:0] nv_sel_o, nv_mode_o, nv_mode_i;
	logic [8:0] nv_opts_o, nv_opts_i;
	logic [8:0] ow [5] = '{9'h001, 9'h005, 9'h004, 9'h10a, 9'h1fe};
	int n_errors = 0, checks_done = 0;

	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (probe_drive_o) seen_probe <= 1;
		if (pwrup_pkt_o) seen_pkt <= 1;
	end

	dcch_handler #(.WAKE_CYC(50), .PROBE_CYC(8)) i_dut (.clk_i, .rst_n_i, .ce_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .nv_mode_i, .nv_opts_i, .nv_ro_i,
		.nv_wr_o, .nv_sel_o, .nv_mode_o, .nv_opts_o, .nv_ro_o, .fault_pin_i,
		.probe_meas_i(meas), .drive_en_o, .probe_drive_o, .anti_res_o, .std_scl_o,
		.addr_char_o, .ack_en_o, .csum_en_o, .full_duplex_o, .pwrup_pkt_o);
	dcch_nv_model i_nv (.clk_i, .wr_i(nv_wr_o), .sel_i(nv_sel_o), .mode_i(nv_mode_o),
		.opts_i(nv_opts_o), .ro_i(nv_ro_o), .mode_o(nv_mode_i), .opts_o(nv_opts_i),
		.ro_o(nv_ro_i));

	task automatic give_verdict;
		$display("errors %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic [31:0] w, input logic r);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= w;
		wr_i <= !r;
		rd_i <= r;
		@(posedge clk_i);
		wr_i <= 0;
		rd_i <= 0;
		@(negedge clk_i);
		d = rdata_o;
	endtask
	// settle time covers queue, execute and decode
	task automatic cmd(input logic [3:0] op, input logic hp, input logic [8:0] p);
		acc(DCCH_CMD_OFS, {7'h0, p, 11'h0, hp, op}, 0);
		repeat (5) @(posedge clk_i);
	endtask
	task automatic wait_probe;
		int n;
		for (n = 0; n < 60 && !(seen_probe && probe_drive_o === 1'b0); n++) @(negedge clk_i);
		if (n == 60) begin
			n_errors++;
			give_verdict();
		end
		repeat (3) @(posedge clk_i);
	endtask
	task automatic boot;
		seen_probe = 0;
		seen_pkt = 0;
		rst_n_i <= 0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1;
		wait_probe();
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		n_errors++;
		give_verdict();
	end

	initial begin
		boot();
		chk(drive_en_o, 1);
		chk(seen_probe, 1);
		acc(DCCH_PROBE_OFS, 0, 1);
		chk(d, {16'h0, meas});
		foreach (ow[i]) begin
			cmd(DCCH_OP_OPTS, 1, ow[i]);
			chk({std_scl_o, addr_char_o, ack_en_o, csum_en_o, full_duplex_o},
				{ow[i][0] && ow[i][8:1] == 0, ow[i][1], ow[i][2], ow[i][3], ow[i][8]});
			cmd(DCCH_OP_OPTS, 0, 0);
			acc(DCCH_REPLY_OFS, 0, 1);
			chk(d, {1'b1, 22'h0, ow[i]});
		end
		cmd(DCCH_OP_ANTIR, 1, 1);
		chk(anti_res_o, 1);
		cmd(DCCH_OP_ANTIR, 1, 2);
		chk(anti_res_o, 1);
		// enable low: the whole command write is ignored
		ce_i <= 0;
		cmd(DCCH_OP_ANTIR, 1, 0);
		ce_i <= 1;
		chk(anti_res_o, 1);
		cmd(DCCH_OP_ANTIR, 1, 0);
		cmd(DCCH_OP_ANTIR, 0, 0);
		acc(DCCH_REPLY_OFS, 0, 1);
		chk({anti_res_o, d}, {1'b0, 32'h80000000});
		cmd(DCCH_OP_MODE, 1, 5);
		cmd(DCCH_OP_MODE, 1, 4);
		acc(DCCH_STATUS_OFS, 0, 1);
		chk({nv_mode_i, d[2:0]}, {3'h5, 3'h5});
		cmd(DCCH_OP_MODE, 0, 0);
		acc(DCCH_REPLY_OFS, 0, 1);
		chk(d, 32'h80000005);
		// pause: later commands wait in the queue
		cmd(DCCH_OP_PAUSE, 0, 0);
		cmd(DCCH_OP_OPTS, 1, 9'h002);
		cmd(DCCH_OP_OPTS, 0, 0);
		cmd(DCCH_OP_OPTS, 1, 9'h100);
		acc(DCCH_STATUS_OFS, 0, 1);
		chk({d[15], d[22:19], csum_en_o}, {1'b1, 4'h3, 1'b1});
		cmd(DCCH_OP_RESUME, 0, 0);
		acc(DCCH_REPLY_OFS, 0, 1);
		chk({d[8:0], csum_en_o, full_duplex_o}, {9'h002, 1'b0, 1'b1});
		cmd(DCCH_OP_ANTIR, 1, 1);
		cmd(DCCH_OP_COMMIT, 0, 0);
		chk({nv_opts_i, nv_ro_i}, {9'h100, 1'b1});
		acc(DCCH_CTRL_OFS, 0, 0);
		chk(drive_en_o, 0);
		acc(DCCH_CTRL_OFS, 1, 0);
		chk(drive_en_o, 1);
		cmd(DCCH_OP_ANTIR, 1, 0);
		fault_pin_i <= 1;
		repeat (5) @(posedge clk_i);
		fault_pin_i <= 0;
		chk(drive_en_o, 0);
		cmd(DCCH_OP_PAUSE, 0, 0);
		cmd(DCCH_OP_WBOOT, 0, 0);
		acc(DCCH_STATUS_OFS, 0, 1);
		chk({d[17], d[15], d[2:0], drive_en_o, anti_res_o}, {5'h05, 2'b01});
		foreach (ow[i]) if (i < 2) begin
			seen_probe = 0;
			cmd(i ? DCCH_OP_ENCF : DCCH_OP_PROBE, 0, 0);
			meas <= 16'h1e2d + 16'(i);
			wait_probe();
			acc(DCCH_PROBE_OFS, 0, 1);
			chk(d, {16'h0, meas});
		end
		cmd(DCCH_OP_MODE, 1, 3);
		chk(nv_mode_i, 3);
		// tool mode: silent until two consecutive wake characters
		boot();
		chk({seen_pkt, drive_en_o}, 2'b10);
		cmd(DCCH_OP_ANTIR, 1, 0);
		chk(anti_res_o, 1);
		acc(DCCH_WAKE_OFS, 32'h30, 0);
		acc(DCCH_WAKE_OFS, 32'h31, 0);
		acc(DCCH_WAKE_OFS, 32'h30, 0);
		acc(DCCH_STATUS_OFS, 0, 1);
		chk(d[16], 0);
		acc(DCCH_WAKE_OFS, 32'h30, 0);
		acc(DCCH_STATUS_OFS, 0, 1);
		chk({d[16], d[2:0]}, 4'hb);
		cmd(DCCH_OP_ANTIR, 1, 0);
		acc(8'h20, 0, 1);
		chk({anti_res_o, d}, 33'h0);
		give_verdict();
	end
endmodule
